// ### rtl/usb_fifo_pkg.sv
// Shared constants and types for the FIFO port control block.
package usb_fifo_pkg;

   // ==========================================================================
   // Sizes
   localparam int           NPIPE        = 10;
   localparam int           NPORT        = 3;
   localparam int           LEN_W        = 6;
   localparam int           MEM_AW       = 9;
   localparam logic [5:0]   SIDE_BYTES   = 6'h20;
   localparam logic [3:0]   CTRL_PIPE    = 4'h0;

   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam logic [2:0][5:0] CTRL_IDX  = {6'h2E, 6'h2A, 6'h22};
   localparam logic [2:0][5:0] SEL_IDX   = {6'h2C, 6'h28, 6'h20};
   localparam logic [2:0][5:0] DATA_IDX  = {6'h1C, 6'h18, 6'h14};

   // ==========================================================================
   // Port control fields
   localparam int           BIT_VALID    = 15;
   localparam int           BIT_CLEAR    = 14;
   localparam int           BIT_READY    = 13;

   // Port select fields
   localparam int           SEL_PIPE_LSB = 0;
   localparam int           SEL_CTLP_BIT = 5;
   localparam int           SEL_BRE_BIT  = 6;
   localparam int           SEL_W16_BIT  = 10;
   localparam int           SEL_CNT_BIT  = 15;
   localparam logic [15:0]  SEL_WR_MASK  = 16'h846F;
   localparam logic [15:0]  SEL_RESET    = 16'h0000;

   // ==========================================================================
   // Timing
   localparam int           CLK_PERIOD_NS = 20;
   localparam int           UPDATE_NS     = 150;
   localparam int           UPDATE_CYC    = (UPDATE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (UPDATE_NS / CLK_PERIOD_NS);

   typedef enum logic {ST_IDLE, ST_RD_WAIT} acc_state_t;

endpackage

// ### rtl/port_cfg.sv
// Port select register of one FIFO port.
module port_cfg
   import usb_fifo_pkg::*;
(
   input  wire logic        pclk,      // bus clock
   input  wire logic        presetn,   // async reset, active low
   input  wire logic        wr_en,     // write strobe
   input  wire logic [15:0] wdata,     // write data
   output logic      [15:0] value      // stored settings
);

   logic [15:0] cfg_q;
   logic [15:0] cfg_d;

   // Reserved bits are masked off so they read back as zero.
   always_comb begin
      cfg_d = cfg_q;
      if (wr_en) begin
         cfg_d = wdata & SEL_WR_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= SEL_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   assign value = cfg_q;

endmodule // port_cfg

// ### rtl/buf_mem.sv
// Dual-port pipe buffer memory with byte enables on port A only and registered read data.
module buf_mem
   import usb_fifo_pkg::*;
(
   input  wire logic              clk,      // clock
   input  wire logic              rst_n,    // async reset for read data
   input  wire logic              a_en,     // port A enable
   input  wire logic              a_we,     // port A write
   input  wire logic [1:0]        a_be,     // port A byte enables
   input  wire logic [MEM_AW-1:0] a_addr,   // port A word address
   input  wire logic [15:0]       a_wdata,  // port A write data
   output logic      [15:0]       a_rdata,  // port A read data
   input  wire logic              b_en,     // port B enable
   input  wire logic              b_we,     // port B write
   input  wire logic [MEM_AW-1:0] b_addr,   // port B word address
   input  wire logic [15:0]       b_wdata,  // port B write data
   output logic      [15:0]       b_rdata   // port B read data
);

   logic [15:0] mem [2**MEM_AW];

   // Port B wins a same-word collision; ports never share a pipe side legally.
   always_ff @(posedge clk) begin
      if (a_en && a_we && a_be[0]) mem[a_addr][7:0] <= a_wdata[7:0];
      if (a_en && a_we && a_be[1]) mem[a_addr][15:8] <= a_wdata[15:8];
      if (b_en && b_we) mem[b_addr] <= b_wdata;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_rdata <= 16'h0000;
         b_rdata <= 16'h0000;
      end else begin
         if (a_en && !a_we) a_rdata <= mem[a_addr];
         if (b_en && !b_we) b_rdata <= mem[b_addr];
      end
   end

endmodule // buf_mem

// ### rtl/usb_fifo_port_control.sv
// APB slave with three FIFO ports over the pipe buffers of the serial engine.
//
// The APB slave port was chosen for this implementation.

// Contract
// - Pipe change keeps access progress per pipe.
// - Valid flag hands buffer to engine.
// - Full continuous buffer hands over automatically.
// - Valid plus clear arms zero-length packet.
// - Clear empties CPU side, reads zero.
// - Double buffer clear empties one side.
// - Control pipe clear empties both sides.
// - Ready bit shows port accessibility.
// - Ready with no data needs clear.
// - Hold mode keeps length until read.
// - Decrement mode drops length per read.
// - Next side length loads after completion.
// - Updated length readable within 150 ns.
// - Three same-layout control registers.
// - Width bit picks 8 or 16 bits.
// - Count mode picks hold or decrement.
module usb_fifo_port_control
   import usb_fifo_pkg::*;
(
   input  wire logic                        pclk,          // APB clock
   input  wire logic                        presetn,       // async reset, active low
   input  wire logic                        psel,          // APB select
   input  wire logic                        penable,       // APB access phase
   input  wire logic                        pwrite,        // APB direction
   input  wire logic [7:0]                  paddr,         // APB byte address
   input  wire logic [31:0]                 pwdata,        // APB write data
   output logic      [31:0]                 prdata,        // APB read data
   output logic                             pready,        // APB ready
   output logic                             pslverr,       // unmapped address
   input  wire logic [NPIPE-1:0]            pipe_tx,       // pipe transmits
   input  wire logic [NPIPE-1:0]            pipe_double,   // pipe double buffered
   input  wire logic [NPIPE-1:0]            pipe_contin,   // pipe continuous mode
   input  wire logic                        eng_en,        // engine memory enable
   input  wire logic                        eng_we,        // engine memory write
   input  wire logic [MEM_AW-1:0]           eng_addr,      // engine word address
   input  wire logic [15:0]                 eng_wdata,     // engine write data
   output logic      [15:0]                 eng_rdata,     // engine read data
   input  wire logic                        eng_rx_done,   // packet received, pulse
   input  wire logic                        eng_tx_done,   // packet sent, pulse
   input  wire logic [3:0]                  eng_done_pipe, // pipe of the pulse
   input  wire logic                        eng_done_side, // side of the pulse
   input  wire logic [LEN_W-1:0]            eng_rx_len,    // received byte count
   output logic      [2*NPIPE-1:0]          side_full,     // side held, per pipe
   output logic      [2*NPIPE*LEN_W-1:0]    side_len       // side length, per pipe
);

   // ==========================================================================
   // Helpers
   function automatic logic port_ready(input logic valid, input logic tx,
                                       input logic full_cs);
      return valid & (tx ? ~full_cs : full_cs);
   endfunction

   function automatic logic [LEN_W-1:0] shown_len(input logic tx, input logic full_cs,
                                                  input logic dec,
                                                  input logic [LEN_W-1:0] len,
                                                  input logic [LEN_W-1:0] ptr);
      if (tx || !full_cs) return '0;
      if (dec) return (ptr >= len) ? '0 : LEN_W'(len - ptr);
      return len;
   endfunction

   // ==========================================================================
   // State
   logic [NPIPE-1:0][1:0]            full_q, full_d;
   logic [NPIPE-1:0][1:0][LEN_W-1:0] len_q, len_d;
   logic [NPIPE-1:0][LEN_W-1:0]      ptr_q, ptr_d;
   logic [NPIPE-1:0]                 side_q, side_d;
   acc_state_t                       st_q, st_d;
   logic                             rd_data_q, rd_data_d;
   logic                             rd_ok_q, rd_ok_d;
   logic [31:0]                      prdata_q, prdata_d;

   // ==========================================================================
   // Port settings and derived status
   logic [NPORT-1:0][15:0]      cfg;
   logic [NPORT-1:0]            cfg_wr;
   logic [NPORT-1:0][3:0]       p_pipe;
   logic [NPORT-1:0]            p_valid, p_tx, p_dbl, p_cont, p_cs, p_full, p_ready;
   logic [NPORT-1:0][LEN_W-1:0] p_len, p_ptr, p_shown;

   for (genvar k = 0; k < NPORT; k++) begin : g_port
      port_cfg u_cfg (
         .pclk    (pclk),
         .presetn (presetn),
         .wr_en   (cfg_wr[k]),
         .wdata   (pwdata[15:0]),
         .value   (cfg[k])
      );
   end

   always_comb begin
      for (int k = 0; k < NPORT; k++) begin
         p_pipe[k]  = cfg[k][SEL_CTLP_BIT] ? CTRL_PIPE : cfg[k][SEL_PIPE_LSB +: 4];
         p_valid[k] = cfg[k][SEL_CTLP_BIT] ||
                      (cfg[k][SEL_PIPE_LSB +: 4] != 4'h0 &&
                       cfg[k][SEL_PIPE_LSB +: 4] < 4'(NPIPE));
         p_tx[k]    = p_valid[k] & pipe_tx[p_pipe[k]];
         p_dbl[k]   = p_valid[k] & pipe_double[p_pipe[k]];
         p_cont[k]  = p_valid[k] & pipe_contin[p_pipe[k]];
         p_cs[k]    = p_valid[k] & side_q[p_pipe[k]];
         p_full[k]  = p_valid[k] & full_q[p_pipe[k]][p_cs[k]];
         p_len[k]   = p_valid[k] ? len_q[p_pipe[k]][p_cs[k]] : '0;
         p_ptr[k]   = p_valid[k] ? ptr_q[p_pipe[k]] : '0;
         p_ready[k] = port_ready(p_valid[k], p_tx[k], p_full[k]);
         p_shown[k] = shown_len(p_tx[k], p_full[k], cfg[k][SEL_CNT_BIT],
                                p_len[k], p_ptr[k]);
      end
   end

   // ==========================================================================
   // Bus decode
   logic [5:0] idx;
   logic [1:0] hp;
   logic       hit_ctrl, hit_sel, hit_data;
   logic       access, wr_done, rd_done, rd_first;

   assign idx = paddr[7:2];

   always_comb begin
      hp       = 2'h0;
      hit_ctrl = 1'b0;
      hit_sel  = 1'b0;
      hit_data = 1'b0;
      for (int k = 0; k < NPORT; k++) begin
         if (idx == CTRL_IDX[k]) begin
            hp       = 2'(k);
            hit_ctrl = 1'b1;
         end
         if (idx == SEL_IDX[k]) begin
            hp      = 2'(k);
            hit_sel = 1'b1;
         end
         if (idx == DATA_IDX[k]) begin
            hp       = 2'(k);
            hit_data = 1'b1;
         end
      end
   end

   // Every read takes one wait state so read data always come from a register.
   assign access   = psel & penable;
   assign pready   = pwrite | (st_q == ST_RD_WAIT);
   assign wr_done  = access & pwrite;
   assign rd_done  = access & !pwrite & (st_q == ST_RD_WAIT);
   assign rd_first = access & !pwrite & (st_q == ST_IDLE);
   assign pslverr  = access & pready & !(hit_ctrl | hit_sel | hit_data);

   always_comb begin
      for (int k = 0; k < NPORT; k++) begin
         cfg_wr[k] = wr_done & hit_sel & (hp == 2'(k));
      end
   end

   // Selected port shortcuts.
   logic [3:0]       sp;
   logic             s_tx, s_dbl, s_cs, s_ready, s_w16, s_bre, s_ctlp, wr_ok, rd_ok;
   logic [LEN_W-1:0] s_ptr, s_len, s_step;

   assign sp      = p_pipe[hp];
   assign s_tx    = p_tx[hp];
   assign s_dbl   = p_dbl[hp];
   assign s_cs    = p_cs[hp];
   assign s_ready = p_ready[hp];
   assign s_ptr   = p_ptr[hp];
   assign s_len   = p_len[hp];
   assign s_w16   = cfg[hp][SEL_W16_BIT];
   assign s_bre   = cfg[hp][SEL_BRE_BIT];
   assign s_ctlp  = cfg[hp][SEL_CTLP_BIT];
   assign s_step  = s_w16 ? LEN_W'(2) : LEN_W'(1);
   assign wr_ok   = hit_data & s_ready & s_tx & (s_ptr < SIDE_BYTES);
   assign rd_ok   = hit_data & s_ready & !s_tx & (s_ptr < s_len);

   // ==========================================================================
   // Buffer memory
   logic [15:0] mem_rdata;
   logic        mem_a_en;

   assign mem_a_en = (wr_done & wr_ok) | (rd_first & rd_ok);

   buf_mem u_mem (
      .clk     (pclk),
      .rst_n   (presetn),
      .a_en    (mem_a_en),
      .a_we    (pwrite),
      .a_be    (s_w16 ? 2'h3 : (s_ptr[0] ? 2'h2 : 2'h1)),
      .a_addr  ({sp, s_cs, s_ptr[4:1]}),
      .a_wdata (s_w16 ? pwdata[15:0] : {pwdata[7:0], pwdata[7:0]}),
      .a_rdata (mem_rdata),
      .b_en    (eng_en),
      .b_we    (eng_we),
      .b_addr  (eng_addr),
      .b_wdata (eng_wdata),
      .b_rdata (eng_rdata)
   );

   // ==========================================================================
   // Read path
   always_comb begin
      st_d      = st_q;
      rd_data_d = rd_data_q;
      rd_ok_d   = rd_ok_q;
      prdata_d  = prdata_q;
      unique case (st_q)
         ST_IDLE: if (rd_first) begin
            st_d      = ST_RD_WAIT;
            rd_data_d = hit_data;
            rd_ok_d   = rd_ok;
            prdata_d  = 32'h0000_0000;
            if (hit_ctrl) begin
               // Clear bit always reads zero.
               prdata_d[BIT_VALID] = s_tx & p_full[hp];
               prdata_d[BIT_READY] = s_ready;
               prdata_d[LEN_W-1:0] = p_shown[hp];
            end else if (hit_sel) begin
               prdata_d[15:0] = cfg[hp];
            end
         end
         ST_RD_WAIT: st_d = ST_IDLE;
      endcase
   end

   always_comb begin
      prdata = prdata_q;
      if (rd_data_q) begin
         prdata = 32'h0000_0000;
         if (rd_ok_q) begin
            prdata[15:0] = s_w16 ? mem_rdata :
                           {8'h00, (s_ptr[0] ? mem_rdata[15:8] : mem_rdata[7:0])};
         end
      end
   end

   // ==========================================================================
   // Pipe buffer state
   always_comb begin
      logic [LEN_W-1:0] nxt;
      nxt    = '0;
      full_d = full_q;
      len_d  = len_q;
      ptr_d  = ptr_q;
      side_d = side_q;
      if (eng_tx_done && eng_done_pipe < 4'(NPIPE)) begin
         full_d[eng_done_pipe][eng_done_side] = 1'b0;
      end
      if (wr_done && hit_ctrl && p_valid[hp]) begin
         if (pwdata[BIT_VALID] && s_tx && s_ready) begin
            full_d[sp][s_cs] = 1'b1;
            len_d[sp][s_cs]  = pwdata[BIT_CLEAR] ? '0 : s_ptr;
            ptr_d[sp]        = '0;
            if (s_dbl) side_d[sp] = ~s_cs;
         end else if (pwdata[BIT_CLEAR]) begin
            ptr_d[sp] = '0;
            if (s_ctlp) begin
               full_d[sp] = 2'h0;
               side_d[sp] = 1'b0;
            end else if (!s_tx) begin
               full_d[sp][s_cs] = 1'b0;
               if (s_dbl) side_d[sp] = ~s_cs;
            end
         end
      end
      if (wr_done && wr_ok) begin
         nxt       = LEN_W'(s_ptr + s_step);
         ptr_d[sp] = nxt;
         if (p_cont[hp] && nxt >= SIDE_BYTES) begin
            full_d[sp][s_cs] = 1'b1;
            len_d[sp][s_cs]  = nxt;
            ptr_d[sp]        = '0;
            if (s_dbl) side_d[sp] = ~s_cs;
         end
      end
      if (rd_done && rd_data_q && rd_ok_q) begin
         nxt       = LEN_W'(s_ptr + s_step);
         ptr_d[sp] = nxt;
         // A short packet in read-end mode stays until software clears it.
         if (nxt >= s_len && !s_bre) begin
            full_d[sp][s_cs] = 1'b0;
            ptr_d[sp]        = '0;
            if (s_dbl) side_d[sp] = ~s_cs;
         end
      end
      // Reception set wins over a clear in the same cycle.
      if (eng_rx_done && eng_done_pipe < 4'(NPIPE)) begin
         full_d[eng_done_pipe][eng_done_side] = 1'b1;
         len_d[eng_done_pipe][eng_done_side]  = eng_rx_len;
      end
   end

   // Pointers live per pipe, not per port, so a reselected pipe resumes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_q    <= '0;
         len_q     <= '0;
         ptr_q     <= '0;
         side_q    <= '0;
         st_q      <= ST_IDLE;
         rd_data_q <= 1'b0;
         rd_ok_q   <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         full_q    <= full_d;
         len_q     <= len_d;
         ptr_q     <= ptr_d;
         side_q    <= side_d;
         st_q      <= st_d;
         rd_data_q <= rd_data_d;
         rd_ok_q   <= rd_ok_d;
         prdata_q  <= prdata_d;
      end
   end

   assign side_full = full_q;
   assign side_len  = len_q;

   // ==========================================================================
   // Checks
   localparam int UPD_MAX = UPDATE_CYC;
   logic             dec_rd;
   logic [1:0]       chk_port_q;
   logic [LEN_W-1:0] chk_exp_q;

   assign dec_rd = rd_done & rd_data_q & rd_ok_q & cfg[hp][SEL_CNT_BIT] &
                   (LEN_W'(s_ptr + s_step) < s_len);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_port_q <= 2'h0;
         chk_exp_q  <= '0;
      end else if (dec_rd) begin
         chk_port_q <= hp;
         chk_exp_q  <= LEN_W'(p_shown[hp] - s_step);
      end
   end

   AST_DEC_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
      dec_rd |-> ##[1:UPD_MAX] (p_shown[chk_port_q] == chk_exp_q))
      else $error("decremented length not shown in time");

   AST_CLR_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_done && !rd_data_q) |-> !prdata[BIT_CLEAR])
      else $error("clear bit read back as one");

   AST_NO_PIPE_NOT_READY: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_first && hit_ctrl && !p_valid[hp]) |=> !prdata[BIT_READY])
      else $error("port ready with no pipe selected");

   AST_VALID_HANDOVER: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_ctrl && pwdata[BIT_VALID] && s_tx && s_ready && !eng_tx_done)
      |=> full_q[$past(sp)][$past(s_cs)] && ptr_q[$past(sp)] == '0)
      else $error("valid flag did not hand the buffer over");

   AST_ZLP_ARM: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_ctrl && pwdata[BIT_VALID] && pwdata[BIT_CLEAR] && s_tx && s_ready)
      |=> len_q[$past(sp)][$past(s_cs)] == '0)
      else $error("zero-length packet not armed");

   AST_CTRL_PIPE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_ctrl && p_valid[hp] && s_ctlp && pwdata[BIT_CLEAR] &&
       !pwdata[BIT_VALID] && !eng_rx_done) |=> full_q[0] == 2'h0)
      else $error("control pipe clear left a side full");

   AST_ONE_SIDE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_ctrl && p_valid[hp] && !s_ctlp && !s_tx && pwdata[BIT_CLEAR] &&
       !pwdata[BIT_VALID] && !eng_rx_done && !eng_tx_done)
      |=> full_q[$past(sp)][~$past(s_cs)] == $past(full_q[sp][~s_cs]))
      else $error("clear touched the other side");

   AST_SELECT_KEEPS_PTR: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_sel) |=> ptr_q == $past(ptr_q))
      else $error("pipe change lost access progress");

   AST_IGNORE_NOT_READY: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && hit_data && !s_ready && !eng_rx_done && !eng_tx_done)
      |=> ptr_q == $past(ptr_q) && full_q == $past(full_q))
      else $error("write to a not-ready port changed state");

   AST_CONT_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_done && wr_ok && p_cont[hp] && LEN_W'(s_ptr + s_step) >= SIDE_BYTES)
      |=> full_q[$past(sp)][$past(s_cs)] && len_q[$past(sp)][$past(s_cs)] == SIDE_BYTES)
      else $error("full continuous buffer not handed over");

endmodule // usb_fifo_port_control

// ### verif/eng_model.sv
// Serial engine stand-in that reports packets received on a pipe.
module eng_model
   import usb_fifo_pkg::*;
(
   input  wire logic             pclk,      // bus clock
   input  wire logic             go_rx,     // report one reception
   input  wire logic [3:0]       pipe,      // pipe of the report
   input  wire logic [LEN_W-1:0] len,       // bytes received
   output logic                  rx_done,   // one-cycle pulse
   output logic      [3:0]       done_pipe, // pulse qualifier
   output logic      [LEN_W-1:0] rx_len     // pulse qualifier
);
   timeunit 1ns;
   timeprecision 1ns;
   // Qualifiers are scrambled outside the pulse so a design that samples them late fails.
   always_ff @(posedge pclk) begin
      rx_done   <= go_rx;
      done_pipe <= go_rx ? pipe : ~pipe;
      rx_len    <= go_rx ? len : ~len;
   end
endmodule // eng_model

// ### verif/tb_top.sv
// Self-checking bench for the FIFO port control block.
module tb_top
   import usb_fifo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic                     go, rxd, eng_en, eng_we, txd, dside;
   logic [7:0]               paddr;
   logic [31:0]              pwdata, prdata, rd;
   logic [NPIPE-1:0]         ptx, pdbl, pcon;
   logic [MEM_AW-1:0]        eng_addr;
   logic [15:0]              eng_wdata, erd;
   logic [3:0]               gpipe, dpipe;
   logic [LEN_W-1:0]         glen, rlen;
   logic [2*NPIPE-1:0]       side_full;
   logic [2*NPIPE*LEN_W-1:0] side_len;
   int                       miscompares, tests_run;
   usb_fifo_port_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pipe_tx(ptx), .pipe_double(pdbl), .pipe_contin(pcon),
      .eng_en(eng_en), .eng_we(eng_we), .eng_addr(eng_addr), .eng_wdata(eng_wdata),
      .eng_rdata(erd), .eng_rx_done(rxd), .eng_tx_done(txd), .eng_done_pipe(dpipe),
      .eng_done_side(dside), .eng_rx_len(rlen), .side_full(side_full), .side_len(side_len));
   eng_model partner (.pclk(pclk), .go_rx(go), .pipe(gpipe), .len(glen), .rx_done(rxd),
      .done_pipe(dpipe), .rx_len(rlen));
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   // ======================================================================
   // Checks and bus cycles
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [5:0] idx, logic [15:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         finish_test();
      end else begin
         rd  = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         // One idle edge keeps two calls from driving the strobes twice in one step.
         @(posedge pclk);
      end
   endtask
   // ======================================================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, go, eng_en, eng_we, txd, dside} = '0;
      {paddr, pwdata, eng_addr, eng_wdata, gpipe, glen, pdbl, pcon} = '0;
      ptx = 10'h02E;
      miscompares = 0;
      tests_run = 0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 6'h3F, 16'h0000);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      for (int p = 0; p < 3; p++) begin
         apb(1, SEL_IDX[p], 16'h0400 | (p + 1));
         apb(0, SEL_IDX[p], 16'h0000);
         chk("select readback", 32'h0400 | (p + 1), rd);
         apb(0, CTRL_IDX[p], 16'h0000);
         chk("ctrl idle", 3'b001, rd[15:13]);
         apb(1, DATA_IDX[p], 16'hA5C3);
         apb(1, CTRL_IDX[p], 16'h8000);
         apb(0, CTRL_IDX[p], 16'h0000);
         chk("ctrl armed", 3'b100, rd[15:13]);
         chk("side full", 1, side_full[(p + 1) * 2]);
         chk("side len", 2, side_len[(p + 1) * 2 * LEN_W +: LEN_W]);
      end
      apb(1, SEL_IDX[0], 16'h0405);
      apb(1, DATA_IDX[0], 16'h1234);
      apb(1, DATA_IDX[0], 16'h5678);
      apb(1, CTRL_IDX[0], 16'hC000);
      chk("zlp full", 1, side_full[10]);
      chk("zlp len", 0, side_len[60 +: LEN_W]);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("clear reads zero", 0, rd[14]);
      eng_en   <= 1'b1;
      eng_addr <= 9'h020;
      @(posedge pclk);
      eng_en <= 1'b0;
      @(posedge pclk);
      chk("engine read", 16'hA5C3, erd);
      eng_en    <= 1'b1;
      eng_we    <= 1'b1;
      eng_addr  <= 9'h080;
      eng_wdata <= 16'hBEEF;
      @(posedge pclk);
      eng_addr  <= 9'h081;
      eng_wdata <= 16'h1234;
      @(posedge pclk);
      eng_en <= 1'b0;
      eng_we <= 1'b0;
      gpipe <= 4'h4;
      glen  <= 6'h06;
      go    <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      apb(1, SEL_IDX[0], 16'h8404);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("rx ready", 1, rd[13]);
      chk("rx len", 6, rd[5:0]);
      apb(0, DATA_IDX[0], 16'h0000);
      chk("rx word", 16'hBEEF, rd);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("dec by two", 4, rd[5:0]);
      apb(1, SEL_IDX[0], 16'h8004);
      apb(0, DATA_IDX[0], 16'h0000);
      chk("rx byte", 16'h0034, rd);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("dec by one", 3, rd[5:0]);
      apb(1, CTRL_IDX[0], 16'h4000);
      chk("rx cleared", 0, side_full[8]);
      apb(1, DATA_IDX[0], 16'h00FF);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("cleared not ready", 0, rd[13:0]);
      gpipe <= 4'h0;
      glen  <= 6'h04;
      go    <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      apb(1, SEL_IDX[0], 16'h0020);
      chk("control rx", 1, side_full[1:0]);
      apb(1, CTRL_IDX[0], 16'h4000);
      chk("control cleared", 0, side_full[1:0]);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("reset clears sides", 0, side_full);
      presetn <= 1'b1;
      apb(0, SEL_IDX[0], 16'h0000);
      chk("reset select", 0, rd);
      apb(0, CTRL_IDX[0], 16'h0000);
      chk("no pipe not ready", 0, rd);
      pcon <= 10'h028;
      apb(1, SEL_IDX[1], 16'h0405);
      apb(1, SEL_IDX[2], 16'h0403);
      for (int i = 0; i < 16; i++) begin
         apb(1, DATA_IDX[1], 16'(i));
         if (i < 8) apb(1, DATA_IDX[2], 16'(i));
      end
      apb(1, CTRL_IDX[2], 16'h8000);
      chk("auto handover", 1, side_full[10]);
      chk("auto length", 32, side_len[60 +: LEN_W]);
      chk("manual length", 16, side_len[36 +: LEN_W]);
      finish_test();
   end
endmodule // tb_top
